// *** common/irq_ctrl_pkg.sv ***
// Constants shared by the interrupt status and command block and its source bank.
package irq_ctrl_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NUM_SRC = 16;
  localparam int unsigned ID_W = 5;
  localparam int unsigned EVT_W = 3;

  // Source positions in every per-source register
  localparam int unsigned SRC_FAST = 0;
  localparam int unsigned SRC_WATCHDOG = 1;
  localparam int unsigned SRC_SOFTWARE = 2;
  localparam int unsigned SRC_SERIAL_A = 3;
  localparam int unsigned SRC_TIMER0 = 4;
  localparam int unsigned SRC_TIMER1 = 5;
  localparam int unsigned SRC_TIMER2 = 6;
  localparam int unsigned SRC_PORT_A = 7;
  localparam int unsigned SRC_NETWORK_A = 8;
  localparam int unsigned SRC_SPI = 9;
  localparam int unsigned SRC_EXT0 = 10;
  localparam int unsigned SRC_EXT1 = 11;
  localparam int unsigned SRC_DSP = 12;
  localparam int unsigned SRC_NETWORK_B = 13;
  localparam int unsigned SRC_SERIAL_B = 14;
  localparam int unsigned SRC_PORT_B = 15;

  // Implemented sources: all sixteen, or all but external line 1
  localparam logic [15:0] SRC_ALL_MASK = 16'hFFFF;
  localparam logic [15:0] SRC_SMALL_PKG_MASK = 16'hF7FF;

  // Byte offsets on the register bus
  localparam logic [ADDR_W-1:0] OFS_NORMAL_VECTOR = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_FAST_VECTOR = 12'h104;
  localparam logic [ADDR_W-1:0] OFS_CUR_SOURCE = 12'h108;
  localparam logic [ADDR_W-1:0] OFS_PENDING = 12'h10C;
  localparam logic [ADDR_W-1:0] OFS_MASK_STATE = 12'h110;
  localparam logic [ADDR_W-1:0] OFS_LINE_STATE = 12'h114;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_CMD = 12'h120;
  localparam logic [ADDR_W-1:0] OFS_DISABLE_CMD = 12'h124;
  localparam logic [ADDR_W-1:0] OFS_CLEAR_CMD = 12'h128;
  localparam logic [ADDR_W-1:0] OFS_FORCE_CMD = 12'h12C;
  localparam logic [ADDR_W-1:0] OFS_DONE_CMD = 12'h130;
  localparam logic [ADDR_W-1:0] OFS_STRAY_ADDR = 12'h134;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 12'h138;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 12'h13C;

  // Line state bits
  localparam int unsigned LINE_FAST_BIT = 0;
  localparam int unsigned LINE_NORMAL_BIT = 1;

  // Event status and event mask bits
  localparam int unsigned EVT_DONE = 0;
  localparam int unsigned EVT_STRAY_NORMAL = 1;
  localparam int unsigned EVT_STRAY_FAST = 2;

  // Reset values
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [NUM_SRC-1:0] RST_SRC = 16'h0000;
  localparam logic [EVT_W-1:0] RST_EVT = 3'h0;
  localparam logic [ID_W-1:0] ID_NONE = 5'h00;

endpackage : irq_ctrl_pkg

// *** rtl/irq_source_bank.sv ***
// Per-source mask and pending state, driven by bit-wise command pulses.
`timescale 1ns/1ps
`default_nettype none

module irq_source_bank
  import irq_ctrl_pkg::*;
#(
  parameter logic [NUM_SRC-1:0] IMPL_MASK = SRC_ALL_MASK
) (
  input wire logic clk, // System clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic [NUM_SRC-1:0] src_active, // Source levels, already polarity corrected
  input wire logic [NUM_SRC-1:0] src_edge_mode, // 1 = edge triggered source
  input wire logic [NUM_SRC-1:0] mask_set, // Enable command bits, one cycle
  input wire logic [NUM_SRC-1:0] mask_clr, // Disable command bits, one cycle
  input wire logic [NUM_SRC-1:0] pend_clr, // Clear command bits, one cycle
  input wire logic [NUM_SRC-1:0] pend_force, // Force command bits, one cycle
  output logic [NUM_SRC-1:0] mask_o, // Mask state, registered
  output logic [NUM_SRC-1:0] pend_o // Pending state, registered
);

  typedef struct packed {
    logic [NUM_SRC-1:0] mask;
    logic [NUM_SRC-1:0] latch;
    logic [NUM_SRC-1:0] prev;
    logic [NUM_SRC-1:0] pend;
  } bank_s;

  bank_s st_r;
  bank_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // A new edge beats a clear arriving in the same cycle so no event is lost
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (IMPL_MASK[i]) begin
        if (mask_set[i]) begin
          st_nxt.mask[i] = 1'b1;
        end else if (mask_clr[i]) begin
          st_nxt.mask[i] = 1'b0;
        end
        st_nxt.latch[i] = (st_r.latch[i] & ~pend_clr[i])
                          | (src_edge_mode[i] & src_active[i] & ~st_r.prev[i])
                          | pend_force[i];
        st_nxt.prev[i] = src_active[i];
        st_nxt.pend[i] = st_r.latch[i] | (~src_edge_mode[i] & src_active[i]);
      end else begin
        st_nxt.mask[i] = 1'b0;
        st_nxt.latch[i] = 1'b0;
        st_nxt.prev[i] = 1'b0;
        st_nxt.pend[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{mask: RST_SRC, latch: RST_SRC, prev: RST_SRC, pend: RST_SRC};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign mask_o = st_r.mask;
  assign pend_o = st_r.pend;

endmodule : irq_source_bank

`default_nettype wire

// *** rtl/irq_status_cmds.sv ***
// Status, command and stray-vector registers of the vectored interrupt controller, on APB.
`timescale 1ns/1ps
`default_nettype none

module irq_status_cmds
  import irq_ctrl_pkg::*;
#(
  parameter bit HAS_EXT1 = 1'b1 // Larger package: external line 1 present
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, 1 = write
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [DATA_W-1:0] pwdata, // APB write data
  output logic [DATA_W-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic [NUM_SRC-1:0] src_active, // Source levels from the source mode logic
  input wire logic [NUM_SRC-1:0] src_edge_mode, // Source trigger type from the source mode logic
  input wire logic [ID_W-1:0] cur_source_id, // Current normal source from the priority logic
  input wire logic [DATA_W-1:0] cur_source_vector, // Vector held for the current source
  input wire logic [DATA_W-1:0] source0_vector, // Vector held for source 0
  output logic [NUM_SRC-1:0] mask_state, // Mask bits to the priority logic
  output logic [NUM_SRC-1:0] pend_state, // Pending bits to the priority logic
  output logic fast_request_line_n, // Fast request to the core, active low
  output logic normal_request_line_n, // Normal request to the core, active low
  output logic handler_done, // One-cycle pulse, end of handling
  output logic normal_vector_taken, // One-cycle pulse, normal vector read while asserted
  output logic evt_irq // Event interrupt, level, active high
);

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] stray_addr;
    logic fast_n;
    logic normal_n;
    logic stray_svc;
    logic line_off;
    logic done;
    logic taken;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_mask;
    logic irq;
    logic [NUM_SRC-1:0] mask;
    logic [NUM_SRC-1:0] pend;
  } ctl_s;

  localparam logic [NUM_SRC-1:0] IMPL_MASK = HAS_EXT1 ? SRC_ALL_MASK : SRC_SMALL_PKG_MASK;

  ctl_s st_r;
  ctl_s st_nxt;
  logic [NUM_SRC-1:0] bank_mask;
  logic [NUM_SRC-1:0] bank_pend;
  logic [NUM_SRC-1:0] cmd_enable;
  logic [NUM_SRC-1:0] cmd_disable;
  logic [NUM_SRC-1:0] cmd_clear;
  logic [NUM_SRC-1:0] cmd_force;
  logic access_done;
  logic wr_done;
  logic rd_done;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, OFS_NORMAL_VECTOR) | hit(a, OFS_FAST_VECTOR) | hit(a, OFS_CUR_SOURCE)
             | hit(a, OFS_PENDING) | hit(a, OFS_MASK_STATE) | hit(a, OFS_LINE_STATE)
             | hit(a, OFS_ENABLE_CMD) | hit(a, OFS_DISABLE_CMD) | hit(a, OFS_CLEAR_CMD)
             | hit(a, OFS_FORCE_CMD) | hit(a, OFS_DONE_CMD) | hit(a, OFS_STRAY_ADDR)
             | hit(a, OFS_EVT_STATUS) | hit(a, OFS_EVT_MASK);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait state, the transfer completes when pready is seen high
  assign access_done = psel & penable & st_r.pready;
  assign wr_done = access_done & pwrite & ~st_r.pslverr;
  assign rd_done = access_done & ~pwrite & ~st_r.pslverr;

  assign cmd_enable = (wr_done && hit(paddr, OFS_ENABLE_CMD)) ? pwdata[NUM_SRC-1:0] : RST_SRC;
  assign cmd_disable = (wr_done && hit(paddr, OFS_DISABLE_CMD)) ? pwdata[NUM_SRC-1:0] : RST_SRC;
  assign cmd_clear = (wr_done && hit(paddr, OFS_CLEAR_CMD)) ? pwdata[NUM_SRC-1:0] : RST_SRC;
  assign cmd_force = (wr_done && hit(paddr, OFS_FORCE_CMD)) ? pwdata[NUM_SRC-1:0] : RST_SRC;

  irq_source_bank #(
    .IMPL_MASK(IMPL_MASK)
  ) u_bank (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .src_active(src_active),
    .src_edge_mode(src_edge_mode),
    .mask_set(cmd_enable),
    .mask_clr(cmd_disable),
    .pend_clr(cmd_clear),
    .pend_force(cmd_force),
    .mask_o(bank_mask),
    .pend_o(bank_pend)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [EVT_W-1:0] evt_set;
    logic [DATA_W-1:0] rd_word;
    logic fast_on;
    logic normal_on;
    evt_set = RST_EVT;
    rd_word = RST_WORD;
    fast_on = ~st_r.fast_n;
    normal_on = ~st_r.normal_n;
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.taken = 1'b0;
    st_nxt.mask = bank_mask;
    st_nxt.pend = bank_pend;

    // Fast line follows source 0 alone; normal line any other enabled pending source
    st_nxt.fast_n = ~(bank_pend[SRC_FAST] & bank_mask[SRC_FAST]);
    st_nxt.normal_n = ~(|(bank_pend[NUM_SRC-1:1] & bank_mask[NUM_SRC-1:1]));

    // Read data is prepared in the first access cycle and held through the ready cycle
    case (paddr)
      OFS_NORMAL_VECTOR: rd_word = normal_on ? cur_source_vector : st_r.stray_addr;
      OFS_FAST_VECTOR: rd_word = fast_on ? source0_vector : st_r.stray_addr;
      OFS_CUR_SOURCE: rd_word = {27'h000_0000, st_r.stray_svc ? ID_NONE : cur_source_id};
      OFS_PENDING: rd_word = {16'h0000, st_r.pend};
      OFS_MASK_STATE: rd_word = {16'h0000, st_r.mask};
      OFS_LINE_STATE: rd_word = {30'h0000_0000, normal_on, fast_on};
      OFS_STRAY_ADDR: rd_word = st_r.stray_addr;
      OFS_EVT_STATUS: rd_word = {29'h0000_0000, st_r.evt_status};
      OFS_EVT_MASK: rd_word = {29'h0000_0000, st_r.evt_mask};
      default: rd_word = RST_WORD;
    endcase

    if (psel && penable && !st_r.pready) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = ~mapped(paddr);
      st_nxt.prdata = pwrite ? RST_WORD : rd_word;
      // Line level as it stood when the vector word was chosen, not a cycle later
      st_nxt.line_off = hit(paddr, OFS_FAST_VECTOR) ? ~fast_on : ~normal_on;
    end else begin
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = RST_WORD;
    end

    if (wr_done) begin
      if (hit(paddr, OFS_STRAY_ADDR)) begin
        st_nxt.stray_addr = pwdata;
      end
      if (hit(paddr, OFS_EVT_MASK)) begin
        st_nxt.evt_mask = pwdata[EVT_W-1:0];
      end
      if (hit(paddr, OFS_DONE_CMD)) begin
        // Data is ignored: the write itself is the signal
        st_nxt.done = 1'b1;
        st_nxt.stray_svc = 1'b0;
        evt_set[EVT_DONE] = 1'b1;
      end
    end

    // Stray state is judged on the line level seen in the read's first access cycle
    if (rd_done && hit(paddr, OFS_NORMAL_VECTOR)) begin
      if (st_r.line_off) begin
        st_nxt.stray_svc = 1'b1;
        evt_set[EVT_STRAY_NORMAL] = 1'b1;
      end else begin
        st_nxt.stray_svc = 1'b0;
        st_nxt.taken = 1'b1;
      end
    end
    if (rd_done && hit(paddr, OFS_FAST_VECTOR) && st_r.line_off) begin
      evt_set[EVT_STRAY_FAST] = 1'b1;
    end

    // Read clears the event status; a new event in the same cycle still lands
    if (rd_done && hit(paddr, OFS_EVT_STATUS)) begin
      st_nxt.evt_status = evt_set;
    end else begin
      st_nxt.evt_status = st_r.evt_status | evt_set;
    end
    st_nxt.irq = |(st_nxt.evt_status & st_nxt.evt_mask);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{prdata: RST_WORD, pready: 1'b0, pslverr: 1'b0, stray_addr: RST_WORD,
                fast_n: 1'b1, normal_n: 1'b1, stray_svc: 1'b0, line_off: 1'b0, done: 1'b0, taken: 1'b0,
                evt_status: RST_EVT, evt_mask: RST_EVT, irq: 1'b0, mask: RST_SRC, pend: RST_SRC};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign mask_state = st_r.mask;
  assign pend_state = st_r.pend;
  assign fast_request_line_n = st_r.fast_n;
  assign normal_request_line_n = st_r.normal_n;
  assign handler_done = st_r.done;
  assign normal_vector_taken = st_r.taken;
  assign evt_irq = st_r.irq;

endmodule : irq_status_cmds

`default_nettype wire

// *** verification/irq_status_cmds_props.sv ***
// Port checker for the status and command block.
`timescale 1ns/1ps
`default_nettype none
module irq_status_cmds_chk
  import irq_ctrl_pkg::*;
#(
  parameter bit HAS_EXT1 = 1'b1 // Larger package
) (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic ce, // Enable
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Direction
  input wire logic [ADDR_W-1:0] paddr, // Address
  input wire logic [DATA_W-1:0] pwdata, // Write data
  input wire logic [DATA_W-1:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic [DATA_W-1:0] source0_vector, // Fast vector
  input wire logic [NUM_SRC-1:0] mask_state, // Mask
  input wire logic [NUM_SRC-1:0] pend_state, // Pending
  input wire logic fast_request_line_n, // Fast line
  input wire logic normal_request_line_n, // Normal line
  input wire logic handler_done, // Done pulse
  input wire logic normal_vector_taken // Taken pulse
);
  localparam logic [15:0] IMPL = HAS_EXT1 ? SRC_ALL_MASK : SRC_SMALL_PKG_MASK;
  logic [DATA_W-1:0] stray_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Shadow of the stray address, so vector reads can be judged from ports alone
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) stray_r <= RST_WORD;
    else if (ce && psel && penable && pready && pwrite && paddr == OFS_STRAY_ADDR) stray_r <= pwdata;
  end
  sequence rd_at(logic [ADDR_W-1:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  sequence wr_at(logic [ADDR_W-1:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  pready_once_a: assert property (pready && ce |=> !pready) else $error("ready held");
  pready_wait_a: assert property (psel && penable && !pready && ce |=> pready) else $error("ready late");
  done_pulse_a: assert property (wr_at(OFS_DONE_CMD) |=> handler_done ##1 !handler_done)
    else $error("done pulse wrong");
  // Lines and mask/pending words are registered on the same edge, so they move together
  fast_line_a: assert property (fast_request_line_n == !(pend_state[0] && mask_state[0]))
    else $error("fast line wrong");
  normal_line_a: assert property (normal_request_line_n == !(|(pend_state[15:1] & mask_state[15:1])))
    else $error("normal line wrong");
  taken_pulse_a: assert property (rd_at(OFS_NORMAL_VECTOR) |=>
    normal_vector_taken == !$past(normal_request_line_n, 2)) else $error("taken pulse wrong");
  line_read_a: assert property (rd_at(OFS_LINE_STATE) |-> prdata ==
    {30'h0000_0000, !$past(normal_request_line_n), !$past(fast_request_line_n)}) else $error("line state read");
  mask_read_a: assert property (rd_at(OFS_MASK_STATE) |-> prdata == {16'h0000, $past(mask_state)})
    else $error("mask read");
  stray_norm_a: assert property (rd_at(OFS_NORMAL_VECTOR) and $past(normal_request_line_n) |->
    prdata == stray_r) else $error("normal stray vector");
  stray_fast_a: assert property (rd_at(OFS_FAST_VECTOR) and $past(fast_request_line_n) |->
    prdata == stray_r) else $error("fast stray vector");
  fast_vec_a: assert property (rd_at(OFS_FAST_VECTOR) and !$past(fast_request_line_n) |->
    prdata == $past(source0_vector)) else $error("fast vector");
  // The bank updates at the completion edge and the mask port one edge later
  mask_set_a: assert property (wr_at(OFS_ENABLE_CMD) |-> ##2
    mask_state == ($past(mask_state, 2) | ($past(pwdata[15:0], 2) & IMPL))) else $error("enable command");
  mask_clr_a: assert property (wr_at(OFS_DISABLE_CMD) |-> ##2
    mask_state == ($past(mask_state, 2) & ~$past(pwdata[15:0], 2))) else $error("disable command");
endmodule : irq_status_cmds_chk
bind irq_status_cmds irq_status_cmds_chk #(.HAS_EXT1(HAS_EXT1)) u_chk (.clk, .arst_n, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .source0_vector, .mask_state, .pend_state, .fast_request_line_n,
  .normal_request_line_n, .handler_done, .normal_vector_taken);
`default_nettype wire

// *** verification/core_side_model.sv ***
// Model of the priority and vector logic beside the block.
`timescale 1ns/1ps
`default_nettype none
module core_side_model
  import irq_ctrl_pkg::*;
#(
  parameter logic [DATA_W-1:0] FAST_VEC = 32'h0000_0F00, // Fast handler
  parameter logic [DATA_W-1:0] VEC_BASE = 32'h0000_1000 // Normal handler base
) (
  input wire logic [NUM_SRC-1:0] mask_state, // Enabled sources
  input wire logic [NUM_SRC-1:0] pend_state, // Pending sources
  output logic [ID_W-1:0] cur_source_id, // Chosen source
  output logic [DATA_W-1:0] cur_source_vector, // Its handler
  output logic [DATA_W-1:0] source0_vector // Fast handler
);
  // Lowest number wins; priority levels are not modelled here
  always_comb begin
    cur_source_id = ID_NONE;
    for (int i = NUM_SRC - 1; i >= 1; i--) begin
      if (pend_state[i] && mask_state[i]) cur_source_id = ID_W'(i);
    end
    cur_source_vector = VEC_BASE + DATA_W'({cur_source_id, 2'b00});
    source0_vector = FAST_VEC;
  end
endmodule : core_side_model
`default_nettype wire

// *** verification/testbench.sv ***
// Register-level bench for the status and command block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench
  import irq_ctrl_pkg::*;
;
  logic clk, arst_n, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd, cur_vec, s0_vec;
  logic [NUM_SRC-1:0] src_active, src_edge_mode, mask_state, pend_state;
  logic [ID_W-1:0] cur_id;
  logic fline_n, nline_n, evt_irq;
  int n_fail = 0;
  int n_tests = 0;
  irq_status_cmds u_irq_status_cmds (.clk, .arst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .src_active, .src_edge_mode, .cur_source_id(cur_id),
    .cur_source_vector(cur_vec), .source0_vector(s0_vec), .mask_state, .pend_state,
    .fast_request_line_n(fline_n), .normal_request_line_n(nline_n), .handler_done(),
    .normal_vector_taken(), .evt_irq);
  core_side_model u_core_side_model (.mask_state, .pend_state, .cur_source_id(cur_id),
    .cur_source_vector(cur_vec), .source0_vector(s0_vec));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // Waits on pready with a bound; a fixed count would hide a late answer
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK({err, rd}, {1'b0, e})
  endtask : rd_chk
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, src_active, src_edge_mode} = '0;
    ce = 1'b1;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_chk(OFS_MASK_STATE, 32'h0000_0000);
    rd_chk(OFS_LINE_STATE, 32'h0000_0000);
    rd_chk(OFS_STRAY_ADDR, 32'h0000_0000);
    rd_chk(OFS_ENABLE_CMD, 32'h0000_0000);
    xfer(1'b0, 12'h118, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    xfer(1'b1, OFS_STRAY_ADDR, 32'hABCD_0120);
    rd_chk(OFS_STRAY_ADDR, 32'hABCD_0120);
    xfer(1'b1, OFS_MASK_STATE, 32'hFFFF_FFFF);
    rd_chk(OFS_MASK_STATE, 32'h0000_0000);
    // Event interrupt: masked, then unmasked, then cleared by reading
    xfer(1'b1, OFS_DONE_CMD, 32'h1234_5678);
    `CHK(evt_irq, 1'b0)
    rd_chk(OFS_EVT_STATUS, 32'h0000_0001);
    xfer(1'b1, OFS_EVT_MASK, 32'h0000_0001);
    xfer(1'b1, OFS_DONE_CMD, 32'h0000_0000);
    `CHK(evt_irq, 1'b1)
    rd_chk(OFS_EVT_STATUS, 32'h0000_0001);
    @(posedge clk);
    `CHK(evt_irq, 1'b0)
    rd_chk(OFS_EVT_STATUS, 32'h0000_0000);
    for (int i = 0; i < NUM_SRC; i++) begin
      xfer(1'b1, OFS_ENABLE_CMD, 32'hFFFF_0000 | (32'h0000_0001 << i));
      rd_chk(OFS_MASK_STATE, (32'h0000_0002 << i) - 32'h0000_0001);
    end
    xfer(1'b1, OFS_DISABLE_CMD, 32'h0000_0001 << SRC_EXT1);
    rd_chk(OFS_MASK_STATE, 32'h0000_F7FF);
    xfer(1'b1, OFS_DISABLE_CMD, 32'h0000_AAAA);
    rd_chk(OFS_MASK_STATE, 32'h0000_5555);
    xfer(1'b1, OFS_FORCE_CMD, 32'h0000_0001 << SRC_FAST);
    rd_chk(OFS_LINE_STATE, 32'h0000_0001);
    rd_chk(OFS_FAST_VECTOR, 32'h0000_0F00);
    xfer(1'b1, OFS_CLEAR_CMD, 32'h0000_0001);
    rd_chk(OFS_FAST_VECTOR, 32'hABCD_0120);
    xfer(1'b1, OFS_FORCE_CMD, 32'h0000_0001 << SRC_SOFTWARE);
    rd_chk(OFS_LINE_STATE, 32'h0000_0002);
    rd_chk(OFS_PENDING, 32'h0000_0004);
    rd_chk(OFS_NORMAL_VECTOR, 32'h0000_1008);
    rd_chk(OFS_CUR_SOURCE, 32'h0000_0002);
    xfer(1'b1, OFS_DONE_CMD, 32'hFFFF_FFFF);
    xfer(1'b1, OFS_CLEAR_CMD, 32'h0000_0004);
    src_active <= 16'h0010;
    repeat (3) @(posedge clk);
    rd_chk(OFS_PENDING, 32'h0000_0010);
    src_active <= 16'h0000;
    repeat (3) @(posedge clk);
    rd_chk(OFS_LINE_STATE, 32'h0000_0000);
    rd_chk(OFS_NORMAL_VECTOR, 32'hABCD_0120);
    rd_chk(OFS_CUR_SOURCE, 32'h0000_0000);
    // A real source arriving during stray service raises the normal line but must not show as current source until the done write
    src_active <= 16'h0010;
    repeat (3) @(posedge clk);
    rd_chk(OFS_LINE_STATE, 32'h0000_0002);
    rd_chk(OFS_CUR_SOURCE, 32'h0000_0000);
    xfer(1'b1, OFS_DONE_CMD, 32'h0000_0000);
    rd_chk(OFS_CUR_SOURCE, 32'h0000_0004);
    // Edge source: a one-cycle pulse is latched, and the clear command removes it
    src_active <= 16'h0000;
    src_edge_mode <= 16'h0040;
    @(posedge clk);
    src_active <= 16'h0040;
    @(posedge clk);
    src_active <= 16'h0000;
    repeat (3) @(posedge clk);
    rd_chk(OFS_PENDING, 32'h0000_0040);
    xfer(1'b1, OFS_CLEAR_CMD, 32'h0000_0040);
    rd_chk(OFS_PENDING, 32'h0000_0000);
    // With the clock enable low an edge pulse must leave no trace
    ce <= 1'b0;
    src_active <= 16'h0040;
    repeat (2) @(posedge clk);
    src_active <= 16'h0000;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    rd_chk(OFS_PENDING, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
